// ===== logic/ddsc_ctrl_port.sv
// ddsc_ctrl_port: serial control port, update strobe and sync clock logic of the synthesizer.
// assumes all pins are asynchronous to ref_clk and the serial clock is well below ref_clk / 8.
//
// Functional notes
// - sync clock is system clock over four, output
// - update strobe sampled at sync clock rise
// - sampled strobe edge gives one load pulse
// - load pulse copies buffers to active registers
// - auto sync steps phase until aligned with input
// - soft sync write advances one system clock
// - soft sync bit clears itself after use
// - hardware sync advances per sync input rise
// - crystal output static until enable bit set
// - whole register transfers, abort may cut short
// - port generates byte addresses by itself
// - first eight rising edges carry instruction
// - data phase length equals register width
// - after last byte, new instruction follows
// - capture on rising, launch on falling edge
// - instruction: read bit, two ignored, address
// - chip select high: outputs off, cycle suspended
// - bit nine picks two-wire or separate output
// - abort input resets port, keeps registers
// - bit eight selects LSB first order
// - auto clear pulses accumulator clear on update
`timescale 1ns/1ps
module ddsc_ctrl_port
   import ddsc_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        sclk,
   input  wire logic        chipSelectN,
   input  wire logic        sdioIn,
   output logic             sdioOut,
   output logic             sdioOe,
   output logic             serialDataOut,
   output logic             serialDataOutOe,
   input  wire logic        portAbortSync,
   input  wire logic        regUpdate,
   input  wire logic        syncIn,
   output logic             syncClk,
   input  wire logic        oscIn,
   output logic             crystalOut,
   output logic             accClear,
   output logic [31:0]      controlFunctionRegOne,
   output logic [23:0]      controlFunctionRegTwo,
   output logic [15:0]      ampScale,
   output logic [7:0]       rampRate,
   output logic [31:0]      frequencyTuningWord,
   output logic [15:0]      phaseOffset
);

   localparam int NPIN = 7;

   logic [NPIN-1:0]        pinLvl;
   logic                   sclkLvl;
   logic                   csNLvl;
   logic                   sdioLvl;
   logic                   abortLvl;
   logic                   updLvl;
   logic                   syncInLvl;
   logic                   oscLvl;
   logic [NUM_BYTES*8-1:0] activeFlat;
   logic [7:0]             memRdData;

   // pins into the system clock domain; chip select idles deselected
   ddsc_pin_sync #(
      .WIDTH (NPIN),
      .INIT  (7'h02)
   ) u_pin_sync (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .pinIn   ({oscIn, syncIn, regUpdate, portAbortSync, sdioIn, chipSelectN, sclk}),
      .level   (pinLvl)
   );

   assign {oscLvl, syncInLvl, updLvl, abortLvl, sdioLvl, csNLvl, sclkLvl} = pinLvl;

   // active register views
   assign controlFunctionRegOne = activeFlat[127:96];
   assign controlFunctionRegTwo = activeFlat[95:72];
   assign ampScale              = activeFlat[71:56];
   assign rampRate              = activeFlat[55:48];
   assign frequencyTuningWord   = activeFlat[47:16];
   assign phaseOffset           = activeFlat[15:0];

   logic lsbFirst;
   logic sepOut;
   assign lsbFirst = controlFunctionRegOne[BIT_LSB_FIRST];
   assign sepOut   = controlFunctionRegOne[BIT_SDIO_UNI];

   // ---------------- sync clock, multi-device alignment and crystal output
   logic [1:0] syncPhase;
   logic [1:0] next_syncPhase;
   logic       next_syncClk;
   logic       syncInPrev;
   logic       syncInRise;
   logic       advance;
   logic       softSync;
   logic       next_crystalOut;

   always_comb begin
      syncInRise = syncInLvl && !syncInPrev;
      softSync   = controlFunctionRegOne[BIT_SOFT_SYNC];
      advance    = 1'b0;
      if (softSync) begin
         advance = 1'b1;
      end
      if (controlFunctionRegTwo[BIT_HW_SYNC] && syncInRise) begin
         advance = 1'b1;
      end
      if (controlFunctionRegOne[BIT_AUTO_SYNC] && syncInRise && syncPhase != AUTO_ALIGN_PH) begin
         advance = 1'b1;
      end
      // skipping one phase moves the sync clock edge a quarter period earlier
      next_syncPhase  = advance ? syncPhase + 2'h2 : syncPhase + 2'h1;
      next_syncClk    = (next_syncPhase == SYNC_RISE_PH) || (next_syncPhase == SYNC_HIGH_LAST);
      next_crystalOut = controlFunctionRegTwo[BIT_XTAL_EN] ? oscLvl : 1'b0;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         syncPhase  <= SYNC_HIGH_LAST;
         syncClk    <= 1'b1;
         syncInPrev <= 1'b0;
         crystalOut <= 1'b0;
      end else begin
         syncPhase  <= next_syncPhase;
         syncClk    <= next_syncClk;
         syncInPrev <= syncInLvl;
         crystalOut <= next_crystalOut;
      end
   end

   // ---------------- update strobe sampling and load
   logic updSample;
   logic next_updSample;
   logic loadPulse;
   logic next_loadPulse;
   logic next_accClear;

   always_comb begin
      next_updSample = updSample;
      next_loadPulse = 1'b0;
      if (next_syncClk && !syncClk) begin
         next_updSample = updLvl;
         next_loadPulse = updLvl && !updSample;
      end
      next_accClear = next_loadPulse && controlFunctionRegOne[BIT_AUTO_CLR];
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         updSample <= 1'b0;
         loadPulse <= 1'b0;
         accClear  <= 1'b0;
      end else begin
         updSample <= next_updSample;
         loadPulse <= next_loadPulse;
         accClear  <= next_accClear;
      end
   end

   // ---------------- serial port
   ddsc_sp_state_e     spState;
   ddsc_sp_state_e     next_spState;
   logic [2:0]         bitCnt;
   logic [2:0]         next_bitCnt;
   logic [7:0]         shiftReg;
   logic [7:0]         next_shiftReg;
   logic [7:0]         txShift;
   logic [7:0]         next_txShift;
   logic               isRead;
   logic               next_isRead;
   logic               addrOk;
   logic               next_addrOk;
   logic [2:0]         bytesLeft;
   logic [2:0]         next_bytesLeft;
   logic [BYTE_AW-1:0] byteAddr;
   logic [BYTE_AW-1:0] next_byteAddr;
   logic               sclkPrev;
   logic               rdPend;
   logic               next_rdPend;
   logic               next_sdioOut;
   logic               next_sdioOe;
   logic               next_sdoOut;
   logic               next_sdoOe;
   logic               sclkRise;
   logic               sclkFall;
   logic [7:0]         rxByte;
   logic [2:0]         width;
   logic               memWrEn;
   logic [BYTE_AW-1:0] memRdAddr;
   logic               txBit;

   always_comb begin
      sclkRise       = sclkLvl && !sclkPrev;
      sclkFall       = !sclkLvl && sclkPrev;
      rxByte         = lsbFirst ? {sdioLvl, shiftReg[7:1]} : {shiftReg[6:0], sdioLvl};
      width          = ddsc_reg_bytes(rxByte[4:0]);
      txBit          = lsbFirst ? txShift[0] : txShift[7];
      next_spState   = spState;
      next_bitCnt    = bitCnt;
      next_shiftReg  = shiftReg;
      next_txShift   = txShift;
      next_isRead    = isRead;
      next_addrOk    = addrOk;
      next_bytesLeft = bytesLeft;
      next_byteAddr  = byteAddr;
      next_rdPend    = 1'b0;
      next_sdioOut   = sdioOut;
      next_sdoOut    = serialDataOut;
      memWrEn        = 1'b0;
      memRdAddr      = byteAddr;
      if (rdPend) begin
         next_txShift = addrOk ? memRdData : 8'h00;
      end
      if (abortLvl) begin
         // registers untouched, only the port restarts
         next_spState   = SP_INSTR;
         next_bitCnt    = 3'h0;
         next_bytesLeft = 3'h0;
      end else if (!csNLvl && sclkRise) begin
         next_shiftReg = rxByte;
         next_bitCnt   = bitCnt + 3'h1;
         if (bitCnt == 3'h7) begin
            case (spState)
               SP_INSTR: begin
                  next_isRead    = rxByte[7];
                  next_addrOk    = rxByte[4:0] <= ADDR_PHASE_OFS;
                  next_bytesLeft = width;
                  next_byteAddr  = lsbFirst ? ddsc_reg_base(rxByte[4:0]) + BYTE_AW'(width - 3'h1)
                                            : ddsc_reg_base(rxByte[4:0]);
                  next_spState   = SP_DATA;
                  memRdAddr      = next_byteAddr;
                  next_rdPend    = rxByte[7];
               end
               SP_DATA: begin
                  memWrEn        = !isRead && addrOk;
                  next_bytesLeft = bytesLeft - 3'h1;
                  next_byteAddr  = lsbFirst ? byteAddr - 4'h1 : byteAddr + 4'h1;
                  if (bytesLeft == 3'h1) begin
                     next_spState = SP_INSTR;
                  end else begin
                     memRdAddr   = next_byteAddr;
                     next_rdPend = isRead;
                  end
               end
               default: begin
                  next_spState = SP_INSTR;
               end
            endcase
         end
      end else if (!csNLvl && sclkFall && spState == SP_DATA && isRead) begin
         next_sdioOut = txBit;
         next_sdoOut  = txBit;
         next_txShift = lsbFirst ? {1'b0, txShift[7:1]} : {txShift[6:0], 1'b0};
      end
      // outputs float while deselected; a suspended cycle keeps its position
      next_sdioOe = !csNLvl && !abortLvl && next_spState == SP_DATA && next_isRead && !sepOut;
      next_sdoOe  = !csNLvl && !abortLvl && next_spState == SP_DATA && next_isRead && sepOut;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         spState         <= SP_INSTR;
         bitCnt          <= 3'h0;
         shiftReg        <= 8'h00;
         txShift         <= 8'h00;
         isRead          <= 1'b0;
         addrOk          <= 1'b0;
         bytesLeft       <= 3'h0;
         byteAddr        <= 4'h0;
         sclkPrev        <= 1'b0;
         rdPend          <= 1'b0;
         sdioOut         <= 1'b0;
         sdioOe          <= 1'b0;
         serialDataOut   <= 1'b0;
         serialDataOutOe <= 1'b0;
      end else begin
         spState         <= next_spState;
         bitCnt          <= next_bitCnt;
         shiftReg        <= next_shiftReg;
         txShift         <= next_txShift;
         isRead          <= next_isRead;
         addrOk          <= next_addrOk;
         bytesLeft       <= next_bytesLeft;
         byteAddr        <= next_byteAddr;
         sclkPrev        <= sclkLvl;
         rdPend          <= next_rdPend;
         sdioOut         <= next_sdioOut;
         sdioOe          <= next_sdioOe;
         serialDataOut   <= next_sdoOut;
         serialDataOutOe <= next_sdoOe;
      end
   end

   // buffer and active register storage
   ddsc_reg_bank u_reg_bank (
      .ref_clk     (ref_clk),
      .reset_n     (reset_n),
      .wrEn        (memWrEn),
      .wrAddr      (byteAddr),
      .wrData      (rxByte),
      .rdAddr      (memRdAddr),
      .rdData      (memRdData),
      .load        (loadPulse),
      .clrSoftSync (softSync),
      .activeFlat  (activeFlat)
   );

endmodule // ddsc_ctrl_port

// ===== logic/ddsc_pin_sync.sv
// ddsc_pin_sync: three-stage synchroniser for pins arriving from outside the system clock.
// assumes asynchronous pins; a change is taken once the second and third stages agree.
`timescale 1ns/1ps
module ddsc_pin_sync #(
   parameter int               WIDTH = 7,
   parameter logic [WIDTH-1:0] INIT  = '0
) (
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] level
);

   // one chain per pin
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic stageOne;
         logic stageTwo;
         logic stageThree;
         logic next_level;

         // accept the new value only when the last two stages agree
         always_comb begin
            next_level = (stageTwo == stageThree) ? stageThree : level[gi];
         end

         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               stageOne   <= INIT[gi];
               stageTwo   <= INIT[gi];
               stageThree <= INIT[gi];
               level[gi]  <= INIT[gi];
            end else begin
               stageOne   <= pinIn[gi];
               stageTwo   <= stageOne;
               stageThree <= stageTwo;
               level[gi]  <= next_level;
            end
         end
      end
   endgenerate

endmodule // ddsc_pin_sync

// ===== logic/ddsc_reg_bank.sv
// ddsc_reg_bank: serial buffer bytes and the active control bytes they are loaded into.
// assumes one writer, a registered read port, and a load pulse from the update path.
`timescale 1ns/1ps
module ddsc_reg_bank
   import ddsc_pkg::*;
(
   input  wire logic                   ref_clk,
   input  wire logic                   reset_n,
   input  wire logic                   wrEn,
   input  wire logic [BYTE_AW-1:0]     wrAddr,
   input  wire logic [7:0]             wrData,
   input  wire logic [BYTE_AW-1:0]     rdAddr,
   output logic      [7:0]             rdData,
   input  wire logic                   load,
   input  wire logic                   clrSoftSync,
   output logic      [NUM_BYTES*8-1:0] activeFlat
);

   logic [7:0] next_rdData;

   // read data always comes from the active copy, through a register
   always_comb begin
      next_rdData = activeFlat[(NUM_BYTES-1-int'(rdAddr))*8 +: 8];
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData <= BYTE_RESET;
      end else begin
         rdData <= next_rdData;
      end
   end

   genvar gb;
   generate
      for (gb = 0; gb < NUM_BYTES; gb++) begin : g_byte
         logic [7:0] bufByte;
         logic [7:0] next_bufByte;
         logic [7:0] next_active;

         // serial writes touch only the buffer; load copies the buffer into the active byte
         always_comb begin
            next_bufByte = (wrEn && wrAddr == BYTE_AW'(gb)) ? wrData : bufByte;
            next_active  = activeFlat[(NUM_BYTES-1-gb)*8 +: 8];
            if (BYTE_AW'(gb) == SOFT_SYNC_BYTE && clrSoftSync) begin
               next_active[SOFT_SYNC_POS] = 1'b0;
            end
            if (load) begin
               next_active = bufByte;
            end
         end

         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               bufByte                            <= BYTE_RESET;
               activeFlat[(NUM_BYTES-1-gb)*8 +: 8] <= BYTE_RESET;
            end else begin
               bufByte                            <= next_bufByte;
               activeFlat[(NUM_BYTES-1-gb)*8 +: 8] <= next_active;
            end
         end
      end
   endgenerate

endmodule // ddsc_reg_bank

// ===== pkg/ddsc_pkg.sv
// ddsc_pkg: constants shared by the synthesizer control port, its register bank, checker and bench.
// assumes a single 200 MHz system clock; register bytes are numbered most significant first.
package ddsc_pkg;

   // system clock rate and derived sync clock division
   localparam int          SYS_CLK_MHZ    = 200;
   localparam int          SYNC_DIV       = 4;
   localparam logic [1:0]  SYNC_RISE_PH   = 2'h0;  // phase at which the sync clock goes high
   localparam logic [1:0]  SYNC_HIGH_LAST = 2'h1;  // last phase of the high half
   localparam logic [1:0]  AUTO_ALIGN_PH  = 2'h3;  // own phase expected when a synced sync input rise is seen

   // byte memory geometry
   localparam int          NUM_BYTES      = 16;
   localparam int          BYTE_AW        = 4;

   // serial register addresses
   localparam logic [4:0]  ADDR_CFR_ONE   = 5'h00;
   localparam logic [4:0]  ADDR_CFR_TWO   = 5'h01;
   localparam logic [4:0]  ADDR_AMP_SCALE = 5'h02;
   localparam logic [4:0]  ADDR_RAMP_RATE = 5'h03;
   localparam logic [4:0]  ADDR_FREQ_WORD = 5'h04;
   localparam logic [4:0]  ADDR_PHASE_OFS = 5'h05;

   // control bit positions within the active registers
   localparam int          BIT_SDIO_UNI   = 9;   // control_function_reg_one: 1 = separate data out pin
   localparam int          BIT_LSB_FIRST  = 8;   // control_function_reg_one: serial bit order
   localparam int          BIT_AUTO_SYNC  = 23;  // control_function_reg_one
   localparam int          BIT_SOFT_SYNC  = 22;  // control_function_reg_one, self clearing
   localparam int          BIT_AUTO_CLR   = 13;  // control_function_reg_one
   localparam int          BIT_HS_SYNC    = 11;  // control_function_reg_two
   localparam int          BIT_HW_SYNC    = 10;  // control_function_reg_two
   localparam int          BIT_XTAL_EN    = 9;   // control_function_reg_two

   // location of the self clearing soft sync bit in the byte memory
   localparam logic [3:0]  SOFT_SYNC_BYTE = 4'h1;
   localparam int          SOFT_SYNC_POS  = 6;

   // reset value of every register byte
   localparam logic [7:0]  BYTE_RESET     = 8'h00;

   // serial port states
   typedef enum logic [1:0] {
      SP_INSTR = 2'b01,
      SP_DATA  = 2'b10
   } ddsc_sp_state_e;

   // width in bytes of a serial register; unknown addresses take one byte
   function automatic logic [2:0] ddsc_reg_bytes(input logic [4:0] addr);
      case (addr)
         ADDR_CFR_ONE:   ddsc_reg_bytes = 3'h4;
         ADDR_CFR_TWO:   ddsc_reg_bytes = 3'h3;
         ADDR_AMP_SCALE: ddsc_reg_bytes = 3'h2;
         ADDR_RAMP_RATE: ddsc_reg_bytes = 3'h1;
         ADDR_FREQ_WORD: ddsc_reg_bytes = 3'h4;
         ADDR_PHASE_OFS: ddsc_reg_bytes = 3'h2;
         default:        ddsc_reg_bytes = 3'h1;
      endcase
   endfunction

   // first (most significant) byte address of a serial register
   function automatic logic [3:0] ddsc_reg_base(input logic [4:0] addr);
      case (addr)
         ADDR_CFR_ONE:   ddsc_reg_base = 4'h0;
         ADDR_CFR_TWO:   ddsc_reg_base = 4'h4;
         ADDR_AMP_SCALE: ddsc_reg_base = 4'h7;
         ADDR_RAMP_RATE: ddsc_reg_base = 4'h9;
         ADDR_FREQ_WORD: ddsc_reg_base = 4'hA;
         ADDR_PHASE_OFS: ddsc_reg_base = 4'hE;
         default:        ddsc_reg_base = 4'h0;
      endcase
   endfunction

endpackage

// ===== test/ddsc_ctrl_port_chk.sv
// ddsc_ctrl_port_chk: port-level timing checks for the synthesizer control port.
// assumes it is bound to ddsc_ctrl_port and sees only that module's ports.
`timescale 1ns/1ps
module ddsc_ctrl_port_chk
   import ddsc_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        reset_n,
   input wire logic        sclk,
   input wire logic        chipSelectN,
   input wire logic        regUpdate,
   input wire logic        sdioOut,
   input wire logic        sdioOe,
   input wire logic        serialDataOutOe,
   input wire logic        syncClk,
   input wire logic        crystalOut,
   input wire logic        accClear,
   input wire logic [31:0] controlFunctionRegOne,
   input wire logic [23:0] controlFunctionRegTwo,
   input wire logic [31:0] frequencyTuningWord
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic [4:0] updCnt;
   logic [4:0] next_updCnt;
   // cycles since the update strobe was last seen high, saturating
   always_comb begin
      next_updCnt = regUpdate ? 5'h00 : ((updCnt == 5'h1F) ? updCnt : updCnt + 5'h01);
   end
   // registers the strobe age counter
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) updCnt <= 5'h1F;
      else updCnt <= next_updCnt;
   end
   a_sync_clk_rate: assert property ($rose(syncClk) |-> ##1 !$rose(syncClk) ##1 !$rose(syncClk)
      ##[1:2] $rose(syncClk)) else $error("sync clock rise spacing wrong");
   a_load_one_shot: assert property ($changed(frequencyTuningWord) |=> $stable(frequencyTuningWord)[*7])
      else $error("active register loaded twice for one strobe");
   a_update_gated: assert property ($changed(frequencyTuningWord) |-> updCnt < 5'h18)
      else $error("active register changed without update strobe");
   a_soft_self_clear: assert property (controlFunctionRegOne[BIT_SOFT_SYNC] |=>
      !controlFunctionRegOne[BIT_SOFT_SYNC]) else $error("soft sync bit did not clear");
   a_xtal_static: assert property ((!controlFunctionRegTwo[BIT_XTAL_EN])[*6] |-> !crystalOut)
      else $error("crystal output moved while disabled");
   a_cs_quiet: assert property (chipSelectN[*8] |-> !sdioOe && !serialDataOutOe)
      else $error("data pin driven while deselected");
   a_bidir_sdo: assert property ((!controlFunctionRegOne[BIT_SDIO_UNI])[*2] |-> !serialDataOutOe)
      else $error("separate out pin driven in two-wire mode");
   a_launch_fall: assert property ($changed(sdioOut) |-> !sclk)
      else $error("read data changed while serial clock high");
   a_acc_pulse: assert property (accClear |=> !accClear)
      else $error("accumulator clear longer than one cycle");
endmodule // ddsc_ctrl_port_chk

bind ddsc_ctrl_port ddsc_ctrl_port_chk u_ddsc_ctrl_port_chk (.ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk),
   .chipSelectN(chipSelectN), .regUpdate(regUpdate), .sdioOut(sdioOut), .sdioOe(sdioOe),
   .serialDataOutOe(serialDataOutOe), .syncClk(syncClk), .crystalOut(crystalOut), .accClear(accClear),
   .controlFunctionRegOne(controlFunctionRegOne), .controlFunctionRegTwo(controlFunctionRegTwo),
   .frequencyTuningWord(frequencyTuningWord));

// ===== test/ddsc_spi_host.sv
// ddsc_spi_host: external controller model that runs serial cycles into the control port.
// assumes the bench resolves the data wire from both drivers; changes land on ref_clk falls.
`timescale 1ns/1ps
module ddsc_spi_host (
   input  wire logic ref_clk,
   output logic      sclk,
   output logic      chipSelectN,
   output logic      hostBit,
   output logic      hostOe,
   input  wire logic sdioLine
);
   // idle: deselected, clock parked low; high speed sync never needed at this rate
   initial begin
      sclk = 1'b0;
      chipSelectN = 1'b1;
      hostBit = 1'b0;
      hostOe = 1'b1;
   end
   // one byte, msb first, 8 cycles per half period; read bit taken just before the rise
   task automatic shiftByte(input logic [7:0] b, input logic rdMode, output logic [7:0] r);
      for (int k = 7; k >= 0; k--) begin
         hostBit = b[k];
         hostOe = !rdMode;
         repeat (8) @(negedge ref_clk);
         r[k] = sdioLine;
         sclk = 1'b1;
         repeat (8) @(negedge ref_clk);
         sclk = 1'b0;
      end
   endtask
   // instruction byte then nsend of n bytes; fewer only when the bench aborts
   task automatic xfer(input logic [7:0] instr, input logic [31:0] data, input int n, input int nsend,
                       output logic [31:0] rd);
      logic [7:0] r;
      rd = 32'h0;
      @(negedge ref_clk);
      chipSelectN = 1'b0;
      repeat (6) @(negedge ref_clk);
      shiftByte(instr, 1'b0, r);
      for (int i = 0; i < nsend; i++) begin
         shiftByte(data[8*(n-1-i) +: 8], instr[7], r);
         rd = {rd[23:0], r};
      end
      repeat (6) @(negedge ref_clk);
      chipSelectN = 1'b1;
      hostOe = 1'b1;
      repeat (8) @(negedge ref_clk);
   endtask
endmodule // ddsc_spi_host

// ===== test/serial_ctrl_port_update_sync_tb.sv
// serial_ctrl_port_update_sync_tb: writes, updates and reads back each control register.
// assumes the host model for serial cycles; inputs change on ref_clk falls.
`timescale 1ns/1ps
module serial_ctrl_port_update_sync_tb;
   import ddsc_pkg::*;
   logic        ref_clk = 1'b0, reset_n = 1'b0, portAbortSync = 1'b0, regUpdate = 1'b0, oscIn = 1'b0, toggle = 1'b0;
   logic        sclk, chipSelectN, hostBit, hostOe, sdioOut, sdioOe, serialDataOut, serialDataOutOe;
   logic        syncClk, crystalOut, accClear, syncIn = 1'b0;
   time         t0;
   wire         sdioLine;
   logic [31:0] control_function_reg_one, ftw, rd;
   logic [23:0] control_function_reg_two;
   logic [15:0] amp, pofs;
   logic [7:0]  ramp;
   int          bad_count = 0, num_checks = 0;
   logic [4:0]  rowAddr [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05};
   logic [31:0] rowData [6] = '{32'h00402000, 32'h00A5A200, 32'h00001234, 32'h00000077, 32'h13579BDF, 32'h00002468};
   logic [31:0] rowExp  [6] = '{32'h00002000, 32'h00A5A200, 32'h00001234, 32'h00000077, 32'h13579BDF, 32'h00002468};
   int          rowLen  [6] = '{4, 3, 2, 1, 4, 2};
   // clock, released-wire pattern and oscillator
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) toggle <= ~toggle;
   always #50 oscIn = ~oscIn;
   assign sdioLine = sdioOe ? sdioOut : (hostOe ? hostBit : toggle);
   ddsc_spi_host u_ddsc_spi_host (.ref_clk(ref_clk), .sclk(sclk), .chipSelectN(chipSelectN), .hostBit(hostBit),
      .hostOe(hostOe), .sdioLine(serialDataOutOe ? serialDataOut : sdioLine));
   ddsc_ctrl_port u_ddsc_ctrl_port (.ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk), .chipSelectN(chipSelectN),
      .sdioIn(sdioLine), .sdioOut(sdioOut), .sdioOe(sdioOe), .serialDataOut(serialDataOut),
      .serialDataOutOe(serialDataOutOe), .portAbortSync(portAbortSync), .regUpdate(regUpdate), .syncIn(syncIn),
      .syncClk(syncClk), .oscIn(oscIn), .crystalOut(crystalOut), .accClear(accClear),
      .controlFunctionRegOne(control_function_reg_one), .controlFunctionRegTwo(control_function_reg_two), .ampScale(amp), .rampRate(ramp),
      .frequencyTuningWord(ftw), .phaseOffset(pofs));
   // active register value by serial address
   function automatic logic [31:0] pick(input logic [4:0] a);
      case (a)
         5'h00: pick = control_function_reg_one;
         5'h01: pick = {8'h00, control_function_reg_two};
         5'h02: pick = {16'h0000, amp};
         5'h03: pick = {24'h000000, ramp};
         5'h04: pick = ftw;
         default: pick = {16'h0000, pofs};
      endcase
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // strobe high two sync periods, then low long enough before the next one
   task automatic update();
      @(negedge ref_clk) regUpdate = 1'b1;
      repeat (8) @(negedge ref_clk);
      regUpdate = 1'b0;
      repeat (16) @(negedge ref_clk);
   endtask
   // watchdog
   initial begin
      #300us;
      bad_count++;
      give_verdict();
   end
   // main sequence
   initial begin
      repeat (4) @(negedge ref_clk);
      check({31'h0, syncClk}, 32'h1);
      repeat (6) @(negedge ref_clk);
      reset_n = 1'b1;
      repeat (10) @(negedge ref_clk);
      for (int i = 0; i < 6; i++) begin
         u_ddsc_spi_host.xfer({3'h0, rowAddr[i]}, rowData[i], rowLen[i], rowLen[i], rd);
         check(pick(rowAddr[i]), 32'h0);
         update();
         check(pick(rowAddr[i]), rowExp[i]);
         u_ddsc_spi_host.xfer({3'h7, rowAddr[i]}, 32'h0, rowLen[i], rowLen[i], rd);
         check(rd, rowExp[i]);
      end
      @(oscIn);
      #1;
      repeat (8) @(negedge ref_clk);
      check({31'h0, crystalOut}, {31'h0, oscIn});
      // hardware sync: one sync input rise pulls the following sync clock rises one system clock earlier
      u_ddsc_spi_host.xfer(8'h01, 32'h00A5A600, 3, 3, rd);
      update();
      @(posedge syncClk) t0 = $time;
      @(negedge ref_clk) syncIn = 1'b1;
      repeat (4) @(posedge syncClk);
      check(32'($time - t0), 32'h0000004B);
      // separate output pin: read data leaves on the second pin
      u_ddsc_spi_host.xfer(8'h00, 32'h00000200, 4, 4, rd);
      update();
      u_ddsc_spi_host.xfer(8'h80, 32'h0, 4, 4, rd);
      check(rd, 32'h00000200);
      // abort after two bytes: those stay in the buffer, the rest is untouched
      u_ddsc_spi_host.xfer(8'h04, 32'hDEADBEEF, 4, 2, rd);
      @(negedge ref_clk) portAbortSync = 1'b1;
      repeat (10) @(negedge ref_clk);
      portAbortSync = 1'b0;
      repeat (10) @(negedge ref_clk);
      u_ddsc_spi_host.xfer(8'h03, 32'h0000005A, 1, 1, rd);
      update();
      check({24'h0, ramp}, 32'h0000005A);
      check(ftw, 32'hDEAD9BDF);
      give_verdict();
   end
endmodule // serial_ctrl_port_update_sync_tb
